//--- common/tdt_pkg.sv
// Package with the register map, field layout and timing constants.
package tdt_pkg;
    localparam int NUM_CH = 3;
    localparam int CW = 32;
    // Printed register offsets; the bus index is the low byte.
    localparam logic [31:0] OFS_PIN_FUNCTION_CONTROL = 32'hfffffe90;
    localparam logic [31:0] OFS_COUNTER_RUN_CONTROL = 32'hfffffe92;
    localparam logic [31:0] OFS_RELOAD_CONSTANT_CH0 = 32'hfffffe94;
    localparam logic [31:0] OFS_DOWN_COUNTER_CH0 = 32'h0ffffe98;
    localparam logic [31:0] OFS_CHANNEL_CONTROL_CH0 = 32'hfffffe9c;
    localparam logic [31:0] OFS_RELOAD_CONSTANT_CH1 = 32'h0ffffea0;
    localparam logic [31:0] OFS_DOWN_COUNTER_CH1 = 32'h0ffffea4;
    localparam logic [31:0] OFS_CHANNEL_CONTROL_CH1 = 32'h0ffffea8;
    localparam logic [31:0] OFS_RELOAD_CONSTANT_CH2 = 32'hfffffeac;
    localparam logic [31:0] OFS_DOWN_COUNTER_CH2 = 32'h0ffffeb0;
    localparam logic [31:0] OFS_CHANNEL_CONTROL_CH2 = 32'h0ffffeb4;
    localparam logic [31:0] OFS_CAPTURE_VALUE_CH2 = 32'hfffffeb8;
    localparam logic [7:0] RELOAD_IDX [NUM_CH] = '{
        OFS_RELOAD_CONSTANT_CH0[7:0], OFS_RELOAD_CONSTANT_CH1[7:0],
        OFS_RELOAD_CONSTANT_CH2[7:0]};
    localparam logic [7:0] COUNTER_IDX [NUM_CH] = '{
        OFS_DOWN_COUNTER_CH0[7:0], OFS_DOWN_COUNTER_CH1[7:0],
        OFS_DOWN_COUNTER_CH2[7:0]};
    localparam logic [7:0] CONTROL_IDX [NUM_CH] = '{
        OFS_CHANNEL_CONTROL_CH0[7:0], OFS_CHANNEL_CONTROL_CH1[7:0],
        OFS_CHANNEL_CONTROL_CH2[7:0]};
    // Reset values.
    localparam logic [7:0] RST_COMMON = 8'h00;
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [31:0] RST_COUNT = 32'h0fffffff;
    // Implemented bits of the channel control registers; the flag bits can only be cleared by a write.
    localparam logic [15:0] CTL_MASK_PLAIN = 16'h013f;
    localparam logic [15:0] CTL_MASK_CAPTURE = 16'h03ff;
    // Field positions.
    localparam int PIN_ROLE_SELECT_BIT = 0;
    localparam int CAPTURE_FLAG_BIT = 9;
    localparam int UNDERFLOW_FLAG_BIT = 8;
    localparam int CAPTURE_EN_HI_BIT = 7;
    localparam int CAPTURE_EN_LO_BIT = 6;
    localparam int UNDERFLOW_IE_BIT = 5;
    localparam int EDGE_HI_BIT = 4;
    localparam int EDGE_LO_BIT = 3;
    localparam int SRC_HI_BIT = 2;
    // Count clock source codes.
    localparam logic [2:0] SRC_DIV4 = 3'h0;
    localparam logic [2:0] SRC_DIV16 = 3'h1;
    localparam logic [2:0] SRC_DIV64 = 3'h2;
    localparam logic [2:0] SRC_DIV256 = 3'h3;
    localparam logic [2:0] SRC_RTC = 3'h4;
    localparam logic [2:0] SRC_PIN = 3'h5;
    // Edge select codes.
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    // Timing.
    localparam int CLK_HZ = 10000000;
    localparam int MAX_COUNT_HZ = 2000000;
    localparam int MIN_TICK_CYCLES =
        (CLK_HZ + MAX_COUNT_HZ - 1) / MAX_COUNT_HZ;
    localparam int PRESCALE_W = 8;
endpackage

//--- src/tdt_timer.sv
// Three channel down timer with a classic Wishbone register slave.
`timescale 1ns/10ps
module tdt_timer #(
    parameter int NUM_CH = tdt_pkg::NUM_CH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rtc_count_clock_i,
    input wire logic standby_i,
    input wire logic timer_multi_pin_i,
    output logic timer_multi_pin_o,
    output logic timer_multi_pin_oe_n_o,
    output logic [2:0] underflow_irq_o,
    output logic capture_irq_o
);
    localparam int CW = tdt_pkg::CW;

    logic [7:0] pin_function_control;
    logic [7:0] counter_run_control;
    logic [15:0] channel_control [NUM_CH];
    logic [CW-1:0] reload_constant [NUM_CH];
    logic [CW-1:0] down_counter [NUM_CH];
    logic [CW-1:0] capture_value;
    logic [15:0] snap_hi;
    logic [tdt_pkg::PRESCALE_W-1:0] prescale;
    logic rtc_prev;
    logic pin_prev;

    // Byte-lane merge of write data into an existing value.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Edge detect chosen by the edge select field.
    function automatic logic edge_hit(input logic [1:0] ckeg,
                                      input logic rise,
                                      input logic fall);
        logic r;
        r = rise | fall;
        if (ckeg == tdt_pkg::EDGE_RISE)
        begin
            r = rise;
        end
        else if (ckeg == tdt_pkg::EDGE_FALL)
        begin
            r = fall;
        end
        return r;
    endfunction

    wire [7:0] idx = adr_i[9:2];
    wire req = cyc_i & stb_i;
    wire wr_en = req & we_i & ack_o;
    wire rd_take = req & ~we_i & ~ack_o;
    wire pin_is_input = ~pin_function_control[tdt_pkg::PIN_ROLE_SELECT_BIT];
    wire pin_rise = pin_is_input & timer_multi_pin_i & ~pin_prev;
    wire pin_fall = pin_is_input & ~timer_multi_pin_i & pin_prev;
    wire rtc_tick = rtc_count_clock_i & ~rtc_prev;
    wire peri_run = ~standby_i;
    wire tick_div4 = peri_run & (prescale[1:0] == 2'h3);
    wire tick_div16 = peri_run & (prescale[3:0] == 4'hf);
    wire tick_div64 = peri_run & (prescale[5:0] == 6'h3f);
    wire tick_div256 = peri_run & (prescale == 8'hff);
    wire hit_pin_fn = idx == tdt_pkg::OFS_PIN_FUNCTION_CONTROL[7:0];
    wire hit_run = idx == tdt_pkg::OFS_COUNTER_RUN_CONTROL[7:0];
    wire hit_capture = idx == tdt_pkg::OFS_CAPTURE_VALUE_CH2[7:0];
    wire [15:0] ctl2 = channel_control[2];
    wire capture_on = ctl2[tdt_pkg::CAPTURE_EN_HI_BIT];
    wire capture_req = capture_on & standby_i == 1'b0 &
        edge_hit(ctl2[tdt_pkg::EDGE_HI_BIT:tdt_pkg::EDGE_LO_BIT],
                 pin_rise, pin_fall);

    logic [NUM_CH-1:0] hit_reload;
    logic [NUM_CH-1:0] hit_counter;
    logic [NUM_CH-1:0] hit_control;
    logic [NUM_CH-1:0] tick;
    logic [31:0] rdata;

    // Per-channel decode and count clock selection.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : gen_sel
            wire [15:0] ctl = channel_control[g];
            wire [1:0] ckeg = ctl[tdt_pkg::EDGE_HI_BIT:tdt_pkg::EDGE_LO_BIT];
            wire [2:0] src = ctl[tdt_pkg::SRC_HI_BIT:0];
            wire pin_tick = peri_run & edge_hit(ckeg, pin_rise, pin_fall);
            assign hit_reload[g] = idx == tdt_pkg::RELOAD_IDX[g];
            assign hit_counter[g] = idx == tdt_pkg::COUNTER_IDX[g];
            assign hit_control[g] = idx == tdt_pkg::CONTROL_IDX[g];
            assign tick[g] = (src == tdt_pkg::SRC_DIV4) ? tick_div4 :
                (src == tdt_pkg::SRC_DIV16) ? tick_div16 :
                (src == tdt_pkg::SRC_DIV64) ? tick_div64 :
                (src == tdt_pkg::SRC_DIV256) ? tick_div256 :
                (src == tdt_pkg::SRC_RTC) ? rtc_tick :
                (src == tdt_pkg::SRC_PIN) ? pin_tick & ~(g == 2 & capture_on)
                : 1'b0;
        end
    endgenerate

    // Read data selection; upper-only counter reads return the snapshot.
    always_comb
    begin
        rdata = 32'h0;
        if (hit_pin_fn)
        begin
            rdata = {24'h0, pin_function_control};
        end
        else if (hit_run)
        begin
            rdata = {24'h0, counter_run_control};
        end
        else if (hit_capture)
        begin
            rdata = capture_value;
        end
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (hit_reload[c])
            begin
                rdata = reload_constant[c];
            end
            if (hit_counter[c])
            begin
                rdata = (sel_i[1:0] == 2'h0) ? {snap_hi, 16'h0} :
                    down_counter[c];
            end
            if (hit_control[c])
            begin
                rdata = {16'h0, channel_control[c]};
            end
        end
    end

    // Bus answer: ack one cycle after the request, dropped the next.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= req & ~ack_o;
            if (rd_take)
            begin
                dat_o <= rdata;
            end
        end
    end

    // Snapshot of the upper half taken whenever byte lane 0 of a counter is read.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            snap_hi <= 16'h0;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (rd_take & hit_counter[c] & sel_i[0])
                begin
                    snap_hi <= down_counter[c][31:16];
                end
            end
        end
    end

    // Common registers, prescaler and input edge history.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_function_control <= tdt_pkg::RST_COMMON;
            counter_run_control <= tdt_pkg::RST_COMMON;
            prescale <= '0;
            rtc_prev <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            prescale <= prescale + 8'h1;
            rtc_prev <= rtc_count_clock_i;
            pin_prev <= timer_multi_pin_i;
            if (wr_en & hit_pin_fn & sel_i[0])
            begin
                pin_function_control <= {7'h0, dat_i[0]};
            end
            if (wr_en & hit_run & sel_i[0])
            begin
                counter_run_control <= {5'h0, dat_i[2:0]};
            end
        end
    end

    // Capture value has no reset; it is written by bus or by capture.
    always_ff @(posedge clk_i)
    begin
        if (wr_en & hit_capture)
        begin
            capture_value <= merge(capture_value, dat_i, sel_i);
        end
        else if (capture_req)
        begin
            capture_value <= down_counter[2];
        end
    end

    // Channel counters, constants and control registers.
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : gen_ch
            localparam logic [15:0] MASK = (g == 2) ?
                tdt_pkg::CTL_MASK_CAPTURE : tdt_pkg::CTL_MASK_PLAIN;
            wire run = counter_run_control[g];
            wire step = run & tick[g];
            wire under = step & (down_counter[g] == 32'h0);
            wire ctl_wr = wr_en & hit_control[g];
            wire [31:0] ctl_merged = merge({16'h0, channel_control[g]},
                dat_i, sel_i);
            wire [15:0] ctl_new = ctl_merged[15:0] & MASK;
            wire clr_unf = ctl_wr & sel_i[1] &
                ~dat_i[tdt_pkg::UNDERFLOW_FLAG_BIT];
            wire clr_icp = ctl_wr & sel_i[1] &
                ~dat_i[tdt_pkg::CAPTURE_FLAG_BIT];
            wire set_icp = (g == 2) & capture_req;
            wire [15:0] old = channel_control[g];
            logic [15:0] next_ctl;
            always_comb
            begin
                next_ctl = ctl_wr ? ctl_new : old;
                next_ctl[tdt_pkg::UNDERFLOW_FLAG_BIT] = under |
                    (old[tdt_pkg::UNDERFLOW_FLAG_BIT] & ~clr_unf);
                next_ctl[tdt_pkg::CAPTURE_FLAG_BIT] = set_icp |
                    (old[tdt_pkg::CAPTURE_FLAG_BIT] & ~clr_icp);
            end
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    channel_control[g] <= tdt_pkg::RST_CONTROL;
                    reload_constant[g] <= tdt_pkg::RST_COUNT;
                    down_counter[g] <= tdt_pkg::RST_COUNT;
                end
                else
                begin
                    channel_control[g] <= next_ctl & MASK;
                    if (wr_en & hit_reload[g])
                    begin
                        reload_constant[g] <= merge(reload_constant[g],
                            dat_i, sel_i);
                    end
                    if (wr_en & hit_counter[g])
                    begin
                        down_counter[g] <= merge(down_counter[g],
                            dat_i, sel_i);
                    end
                    else if (under)
                    begin
                        down_counter[g] <= reload_constant[g];
                    end
                    else if (step)
                    begin
                        down_counter[g] <= down_counter[g] - 32'h1;
                    end
                end
            end
        end
    endgenerate

    // Interrupt requests and the timer pin drive.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            underflow_irq_o <= 3'h0;
            capture_irq_o <= 1'b0;
            timer_multi_pin_o <= 1'b0;
            timer_multi_pin_oe_n_o <= 1'b1;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                underflow_irq_o[c] <=
                    channel_control[c][tdt_pkg::UNDERFLOW_FLAG_BIT] &
                    channel_control[c][tdt_pkg::UNDERFLOW_IE_BIT];
            end
            capture_irq_o <= ctl2[tdt_pkg::CAPTURE_FLAG_BIT] &
                ctl2[tdt_pkg::CAPTURE_EN_HI_BIT] &
                ctl2[tdt_pkg::CAPTURE_EN_LO_BIT];
            timer_multi_pin_o <= rtc_count_clock_i;
            timer_multi_pin_oe_n_o <= pin_is_input;
        end
    end
endmodule

//--- bench/tdt_timer_sva.sv
// Checker for the timer register slave, pin and interrupt outputs.
`timescale 1ns/10ps
module tdt_timer_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rtc_count_clock_i,
    input wire logic timer_multi_pin_o,
    input wire logic timer_multi_pin_oe_n_o,
    input wire logic [2:0] underflow_irq_o,
    input wire logic capture_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i;
    wire wr = req && we_i && ack_o;
    wire rd = req && !we_i && ack_o;
    wire [7:0] idx = adr_i[9:2];
    a_ack_follows: assert property (req && !ack_o |=> ack_o)
        else $error("request not acknowledged");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_reset_state: assert property ($fell(rst_i) |-> !ack_o
        && dat_o == 32'h0 && underflow_irq_o == 3'h0 && !capture_irq_o
        && timer_multi_pin_oe_n_o) else $error("bad outputs after reset");
    a_pin_role: assert property (wr && idx == 8'h90 && sel_i[0]
        |-> ##2 timer_multi_pin_oe_n_o == !$past(dat_i[0], 2))
        else $error("pin enable does not follow role bit");
    a_rtc_out: assert property (!$past(rst_i)
        |-> timer_multi_pin_o == $past(rtc_count_clock_i))
        else $error("pin output is not the rtc clock");
    a_flag_clear: assert property (
        |($past(underflow_irq_o) & ~underflow_irq_o)
        |-> $past(wr) || $past(wr, 2)) else $error("irq fell without write");
    a_capture_clear: assert property ($fell(capture_irq_o)
        |-> $past(wr) || $past(wr, 2)) else $error("capture irq fell alone");
    a_common_width: assert property (rd && idx[7:2] == 6'h24
        |-> dat_o[31:8] == 24'h0) else $error("common register too wide");
    a_control_width: assert property (rd && (idx == 8'h9c
        || idx == 8'ha8 || idx == 8'hb4) |-> dat_o[31:16] == 16'h0)
        else $error("control register too wide");
endmodule
bind tdt_timer tdt_timer_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rtc_count_clock_i,
    .timer_multi_pin_o, .timer_multi_pin_oe_n_o, .underflow_irq_o,
    .capture_irq_o);

//--- bench/tdt_timer_tb.sv
// Self-checking bench for the three channel down timer.
`timescale 1ns/10ps
module tdt_timer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [9:0] adr_i = 10'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic rtc_count_clock_i = 1'b0;
    logic standby_i = 1'b0;
    logic timer_multi_pin_i = 1'b0;
    logic [6:0] rtc_div = 7'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic timer_multi_pin_o;
    logic timer_multi_pin_oe_n_o;
    logic [2:0] underflow_irq_o;
    logic capture_irq_o;
    logic [31:0] rd;
    logic [31:0] ex;
    int fails = 0;
    int samples_checked = 0;
    int i;
    tdt_timer dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .rtc_count_clock_i, .standby_i,
        .timer_multi_pin_i, .timer_multi_pin_o, .timer_multi_pin_oe_n_o,
        .underflow_irq_o, .capture_irq_o);
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        rtc_div <= rtc_div + 7'h1;
        rtc_count_clock_i <= rtc_div[5];
    end
    task automatic wb(input logic w, input logic [7:0] idx,
        input logic [3:0] s, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] idx,
        input logic [31:0] e);
        wb(1'b0, idx, 4'hf, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #(100 * 20000);
        fails++;
        end_of_test;
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk("pin_function", 8'h90, 32'h0);
        rchk("run_control", 8'h92, 32'h0);
        for (i = 0; i < 3; i++)
        begin
            rchk("reload", tdt_pkg::RELOAD_IDX[i], tdt_pkg::RST_COUNT);
            rchk("count", tdt_pkg::COUNTER_IDX[i], tdt_pkg::RST_COUNT);
            rchk("control", tdt_pkg::CONTROL_IDX[i], 32'h0);
            wb(1'b1, tdt_pkg::CONTROL_IDX[i], 4'h3, 32'hffff);
            ex = (i == 2) ? 32'h00ff : 32'h003f;
            rchk("control_bits", tdt_pkg::CONTROL_IDX[i], ex);
            wb(1'b1, tdt_pkg::CONTROL_IDX[i], 4'h3, 32'h0);
            wb(1'b1, tdt_pkg::RELOAD_IDX[i], 4'hf, 32'ha5a5a500 + 32'(i));
            ex = 32'ha5a5a500 + 32'(i);
            rchk("reload_rw", tdt_pkg::RELOAD_IDX[i], ex);
        end
        wb(1'b1, 8'h91, 4'hf, 32'hffffffff);
        rchk("unmapped", 8'h91, 32'h0);
        wb(1'b1, 8'h90, 4'h1, 32'h1);
        rchk("pin_role", 8'h90, 32'h1);
        chk("oe_n_drive", 32'h0, {31'h0, timer_multi_pin_oe_n_o});
        wb(1'b1, 8'h90, 4'h1, 32'h0);
        rchk("pin_role", 8'h90, 32'h0);
        chk("oe_n_release", 32'h1, {31'h0, timer_multi_pin_oe_n_o});
        wb(1'b1, 8'h94, 4'hf, 32'h100);
        wb(1'b1, 8'h98, 4'hf, 32'h1);
        wb(1'b1, 8'h9c, 4'h3, 32'h20);
        wb(1'b1, 8'h92, 4'h1, 32'h1);
        while (underflow_irq_o[0] !== 1'b1)
            @(posedge clk_i);
        wb(1'b1, 8'h92, 4'h1, 32'h0);
        wb(1'b0, 8'h98, 4'hf, 32'h0);
        chk("reloaded", 32'h1, {31'h0, rd > 32'hf0 && rd <= 32'h100});
        rchk("halted", 8'h98, rd);
        rchk("flag_set", 8'h9c, 32'h120);
        wb(1'b1, 8'h9c, 4'h3, 32'h120);
        rchk("flag_keep", 8'h9c, 32'h120);
        wb(1'b1, 8'h9c, 4'h3, 32'h20);
        rchk("flag_clear", 8'h9c, 32'h20);
        chk("irq_clear", 32'h0, {29'h0, underflow_irq_o});
        for (i = 0; i < 4; i++)
        begin
            wb(1'b1, 8'h98, 4'hf, 32'h1000);
            wb(1'b1, 8'h9c, 4'h3, 32'(i));
            wb(1'b1, 8'h92, 4'h1, 32'h1);
            repeat (1024) @(posedge clk_i);
            wb(1'b1, 8'h92, 4'h1, 32'h0);
            wb(1'b0, 8'h98, 4'hf, 32'h0);
            ex = 32'h1000 - (32'd1026 >> (2 * i + 2));
            chk("rate", 32'h1, {31'h0, rd + 1 >= ex && rd <= ex + 1});
        end
        wb(1'b1, 8'h98, 4'hf, 32'h10001);
        wb(1'b1, 8'h92, 4'h1, 32'h1);
        wb(1'b0, 8'h98, 4'h3, 32'h0);
        wb(1'b1, 8'h98, 4'hf, 32'h20000);
        wb(1'b0, 8'h98, 4'hc, 32'h0);
        chk("snapshot", 32'h1, {16'h0, rd[31:16]});
        wb(1'b1, 8'h92, 4'h1, 32'h0);
        wb(1'b1, 8'hb8, 4'hf, 32'hcafe0123);
        rchk("capture_rw", 8'hb8, 32'hcafe0123);
        wb(1'b1, 8'hb0, 4'hf, 32'h12345678);
        wb(1'b1, 8'hb4, 4'h3, 32'hc0);
        timer_multi_pin_i <= 1'b1;
        while (capture_irq_o !== 1'b1)
            @(posedge clk_i);
        rchk("capture", 8'hb8, 32'h12345678);
        rchk("capture_flag", 8'hb4, 32'h2c0);
        wb(1'b1, 8'hb4, 4'h3, 32'hc0);
        @(posedge clk_i);
        chk("capture_irq", 32'h0, {31'h0, capture_irq_o});
        wb(1'b1, 8'h98, 4'hf, 32'h100);
        wb(1'b1, 8'h9c, 4'h3, 32'hd);
        wb(1'b1, 8'h92, 4'h1, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            timer_multi_pin_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            timer_multi_pin_i <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
        wb(1'b1, 8'h92, 4'h1, 32'h0);
        rchk("pin_clock", 8'h98, 32'h100 - 32'd3);
        standby_i <= 1'b1;
        wb(1'b1, 8'h98, 4'hf, 32'h50);
        wb(1'b1, 8'ha4, 4'hf, 32'h1);
        wb(1'b1, 8'ha8, 4'h3, 32'h24);
        wb(1'b1, 8'h92, 4'h1, 32'h3);
        while (underflow_irq_o[1] !== 1'b1)
            @(posedge clk_i);
        rchk("standby_hold", 8'h98, 32'h50);
        wb(1'b1, 8'h90, 4'h1, 32'h1);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        standby_i <= 1'b0;
        @(posedge clk_i);
        rchk("pin_after_reset", 8'h90, 32'h0);
        rchk("run_after_reset", 8'h92, 32'h0);
        end_of_test;
    end
endmodule
